/* rtcmc_top.sv */
`timescale 1ns/1ns
`include "rtcmc_map.svh"
module rtcmc_top #(
  parameter int TICK_DIV = `RTCMC_TICK_DIV
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_soft_rst,
  input wire logic i_load,
  input wire logic [31:0] i_load_value,
  input wire logic i_match_wr,
  input wire logic [31:0] i_match_value,
  input wire logic i_irq_clr,
  output logic [31:0] o_current_count,
  output logic [31:0] o_match_value,
  output logic o_irq
);
  // ==========================================================================
  // State.
  rtcmc_pkg::rtcmc_cnt_t load_value_reg_q;
  rtcmc_pkg::rtcmc_cnt_t current_count_reg_q;
  rtcmc_pkg::rtcmc_cnt_t match_value_reg_q;
  logic irq_q;
  logic hit;
  logic [31:0] tick_gap_q;
  rtcmc_tick_if tick_if ();

  // ==========================================================================
  // Elaboration checks.
  // The word width is fixed by the counting rule, and a divider of zero
  // would space the counting steps 2^32 clock cycles apart.
  initial
  begin
    if (`RTCMC_CNT_W != 32)
    begin
      $error("Counter must be 32 bits wide");
    end
    if (TICK_DIV < 1)
    begin
      $error("TICK_DIV must be at least one");
    end
  end

  // ==========================================================================
  // Helpers.
  // Both resets clear the same state, so the decode lives in one place.
  // The match register deliberately does not use it: software keeps its
  // programmed alarm across a soft reset.
  function automatic logic rtcmc_clear_f(input logic rst_n, input logic soft_rst);
    return !rst_n || soft_rst;
  endfunction

  // One-hertz enable from the main clock; the only counting event.
  rtcmc_tick_div #(
    .DIV(TICK_DIV)
  ) u_div (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_restart(i_soft_rst || i_load),
    .tick_if(tick_if)
  );

  // Load register keeps the last programmed start value.
  always_ff @(posedge i_mclk)
  begin
    if (rtcmc_clear_f(i_rst_n, i_soft_rst))
    begin
      load_value_reg_q <= `RTCMC_CNT_RST;
    end
    else if (i_load)
    begin
      load_value_reg_q <= i_load_value;
    end
  end

  // Counter: load wins over a tick, wraps at the top, never stops.
  // A match has no effect here, so an alarm never disturbs the time base.
  always_ff @(posedge i_mclk)
  begin
    if (rtcmc_clear_f(i_rst_n, i_soft_rst))
    begin
      current_count_reg_q <= `RTCMC_CNT_RST;
    end
    else if (i_load)
    begin
      current_count_reg_q <= i_load_value;
    end
    else if (tick_if.tick)
    begin
      current_count_reg_q <= current_count_reg_q + `RTCMC_CNT_ONE;
    end
  end

  // Match value updates at any time; compare always uses the stored copy.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      match_value_reg_q <= `RTCMC_CNT_RST;
    end
    else if (i_match_wr)
    begin
      match_value_reg_q <= i_match_value;
    end
  end

  assign hit = (current_count_reg_q == match_value_reg_q);

  // Sticky flag; a new match in the clear cycle wins so no event is lost.
  // Limitation: while the count rests on the match value the flag cannot be
  // cleared; software must wait for the next counting step.
  always_ff @(posedge i_mclk)
  begin
    if (rtcmc_clear_f(i_rst_n, i_soft_rst))
    begin
      irq_q <= 1'b0;
    end
    else if (hit)
    begin
      irq_q <= 1'b1;
    end
    else if (i_irq_clr)
    begin
      irq_q <= 1'b0;
    end
  end

  assign o_current_count = current_count_reg_q;
  assign o_match_value = match_value_reg_q;
  assign o_irq = irq_q;

  // ==========================================================================
  // Check helper.
  // Cycles since the last tick or restart, so a check can confirm that the
  // counting steps keep their spacing independently of the divider.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || i_soft_rst || i_load || tick_if.tick)
    begin
      tick_gap_q <= 32'h0000_0000;
    end
    else
    begin
      tick_gap_q <= tick_gap_q + `RTCMC_CNT_ONE;
    end
  end

  // ==========================================================================
  // Checks.
  // Some checks name the rule that they guard in a comment just above their label line.
  tick_gap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    tick_if.tick |-> tick_gap_q == 32'(TICK_DIV - 1))
    else $error("tick spacing wrong");

  // A restart must swallow the tick of its own cycle.
  tick_none_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_soft_rst || i_load) |-> !tick_if.tick)
    else $error("tick during restart");

  count_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_soft_rst && !i_load && tick_if.tick) |=> o_current_count == $past(o_current_count) + 32'h1)
    else $error("count did not step by one");
  count_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!i_soft_rst && !i_load && !tick_if.tick) |=> $stable(o_current_count))
    else $error("count moved without tick");
  load_take_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_load && !i_soft_rst) |=> o_current_count == $past(i_load_value))
    else $error("load value not taken");

  // The stored start value must follow the same strobe as the counter.
  load_reg_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_load && !i_soft_rst) |=> load_value_reg_q == $past(i_load_value))
    else $error("load register not written");

  // The top of the range rolls over to zero rather than sticking.
  count_wrap_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (tick_if.tick && !i_load && !i_soft_rst && o_current_count == `RTCMC_CNT_TOP)
    |=> o_current_count == `RTCMC_CNT_RST)
    else $error("count did not wrap");
  irq_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (hit && !i_soft_rst) |=> o_irq)
    else $error("match did not raise interrupt");
  irq_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_irq && !i_irq_clr && !i_soft_rst) |=> o_irq)
    else $error("interrupt dropped without clear");

  // A clear away from a match must take effect at once.
  irq_clr_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_irq && i_irq_clr && !hit && !i_soft_rst) |=> !o_irq)
    else $error("interrupt clear ignored");

  // A clear that meets a match loses, so the event is not dropped.
  irq_win_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (hit && i_irq_clr && !i_soft_rst) |=> o_irq)
    else $error("clear beat a match");
  match_cont_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (hit && tick_if.tick && !i_load && !i_soft_rst) |=> !hit || $past(o_match_value) != o_match_value)
    else $error("counter stopped at match");
  match_new_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_match_wr |=> o_match_value == $past(i_match_value))
    else $error("match value not updated");
  soft_rst_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_soft_rst |=> o_current_count == `RTCMC_CNT_RST && !o_irq)
    else $error("soft reset incomplete");

  // The alarm setting survives a soft reset.
  match_keep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_soft_rst && !i_match_wr) |=> $stable(o_match_value))
    else $error("soft reset lost match value");
endmodule

/* rtcmc_map.svh */
`ifndef RTCMC_MAP_SVH
`define RTCMC_MAP_SVH

// ==========================================================================
// Constants of the match counter.
`define RTCMC_CNT_W 32
`define RTCMC_CNT_RST 32'h0000_0000
`define RTCMC_CNT_ONE 32'h0000_0001
`define RTCMC_CNT_TOP 32'hFFFF_FFFF
`define RTCMC_MCLK_HZ 125000000
`define RTCMC_TICK_HZ 1
`define RTCMC_TICK_DIV (`RTCMC_MCLK_HZ / `RTCMC_TICK_HZ)

`endif

/* rtcmc_pkg.sv */
package rtcmc_pkg;
  typedef logic [31:0] rtcmc_cnt_t;
endpackage

/* rtcmc_tick_if.sv */
`timescale 1ns/1ns
// ==========================================================================
// Carries the one-second enable from the divider to the counter.
interface rtcmc_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

/* rtcmc_tick_div.sv */
`timescale 1ns/1ns
`include "rtcmc_map.svh"
// ==========================================================================
// Divider: one-cycle enable once every DIV clock cycles.
module rtcmc_tick_div #(
  parameter int DIV = `RTCMC_TICK_DIV
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  rtcmc_tick_if.src tick_if
);
  logic [31:0] div_q;

  initial
  begin
    if (DIV < 1)
    begin
      $error("DIV must be at least one");
    end
  end

  // Restart keeps the first second whole after a soft reset or load.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n || i_restart)
    begin
      div_q <= 32'h0000_0000;
    end
    else if (div_q == 32'(DIV - 1))
    begin
      div_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  assign tick_if.tick = i_rst_n && !i_restart && (div_q == 32'(DIV - 1));
endmodule

/* tb.sv */
`timescale 1ns/1ns
// ==========================================================================
// Bench for the match counter, with a short tick so a run stays brief.
module tb;
  logic i_mclk, i_rst_n, i_soft_rst, i_load, i_match_wr, i_irq_clr, o_irq;
  logic [31:0] i_load_value, i_match_value, o_current_count, o_match_value;
  int fails, tests_run, cyc, n;
  rtcmc_top #(.TICK_DIV(4)) u_rtcmc_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_soft_rst(i_soft_rst), .i_load(i_load), .i_load_value(i_load_value),
    .i_match_wr(i_match_wr), .i_match_value(i_match_value),
    .i_irq_clr(i_irq_clr), .o_current_count(o_current_count),
    .o_match_value(o_match_value), .o_irq(o_irq));
  // Free-running clock and a cycle ceiling against hangs.
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // Inputs move 1 ns after an edge, so no race with the design.
  task automatic step(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Waits, bounded, for the count to move; n gets the cycles taken.
  task automatic wait_move(input logic [31:0] e);
    logic [31:0] old;
    old = o_current_count;
    n = 0;
    while (o_current_count === old && n < 12)
    begin
      step(1);
      n++;
    end
    chk(e, o_current_count);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Load near the top, step by one, wrap, and keep the tick spacing.
  task automatic t_count();
    i_load = 1'b1;
    i_load_value = 32'hFFFFFFFE;
    step(1);
    i_load = 1'b0;
    step(1);
    chk(32'hFFFFFFFE, o_current_count);
    wait_move(32'hFFFFFFFF);
    wait_move(32'h00000000);
    chk(32'h00000004, 32'(n));
  endtask
  // Match raised, newest match used, counting goes on, flag held, cleared.
  task automatic t_match();
    i_load = 1'b1;
    i_load_value = 32'h0000000A;
    i_match_wr = 1'b1;
    i_match_value = 32'h0000000C;
    i_irq_clr = 1'b1;
    step(1);
    i_load = 1'b0;
    i_match_value = 32'h0000000B;
    step(1);
    i_match_wr = 1'b0;
    i_irq_clr = 1'b0;
    step(1);
    chk(32'h00000000, {31'h0, o_irq});
    chk(32'h0000000B, o_match_value);
    n = 0;
    while (o_irq !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    chk(32'h0000000B, o_current_count);
    wait_move(32'h0000000C);
    chk(32'h00000001, {31'h0, o_irq});
    i_irq_clr = 1'b1;
    step(1);
    i_irq_clr = 1'b0;
    step(1);
    chk(32'h00000000, {31'h0, o_irq});
  endtask
  // Soft reset clears count but keeps the match value; the flag enters already cleared and is only checked low.
  task automatic t_soft();
    i_soft_rst = 1'b1;
    step(1);
    i_soft_rst = 1'b0;
    step(1);
    chk(32'h00000000, o_current_count);
    chk(32'h0000000B, o_match_value);
    chk(32'h00000000, {31'h0, o_irq});
  endtask
  initial
  begin
    {i_rst_n, i_soft_rst, i_load, i_match_wr, i_irq_clr} = 5'h00;
    i_load_value = 32'h0;
    i_match_value = 32'h0;
    step(16);
    i_rst_n = 1'b1;
    t_count();
    t_match();
    t_soft();
    report_and_stop();
  end
endmodule
